// [hw/esc_config_regs.v]
// extended setup and floppy output configuration registers with their control effects
//
// Summary of operation
// - extended setup register sits at index 04h in configuration state, resets to 00h
// - bits 1:0 pick parallel mode: standard, epp+standard, ecp, ecp+epp
// - in ecp+epp setting, ecr mode 100 enters epp operation
// - in ecp settings, ecr mode 000 enters standard parallel operation
// - bits 3:2 pick parallel floppy routing: normal, option one, option two, reserved
// - bit 4 makes first serial prescaler divide by 12, else 13
// - bit 5 makes second serial prescaler divide by 12, else 13
// - midi divisor of 12 gives 31.25 kbaud from a 24 MHz reference
// - bit 6 picks epp revision: 0 is 1.9, 1 is 1.7
// - floppy output register sits at index 05h in configuration state, resets to 00h
// - floppy register bits 7:5 and setup bit 7 always read zero
// - floppy bit 0: open-drain outputs when 0, push-pull when 1
// - floppy bit 1: outputs driven when 0, floppy outputs and density pin high-z when 1
// - floppy bits 1:0 do not touch the floppy routed through parallel port
// - floppy bit 2: burst dma when 0, per-byte request and interrupt strobes when 1 with the fifo enabled
// - driven outputs: density pin normal when override 0, forced high when 1
// - tristated outputs: override ignored, density pin stays high-z
`timescale 1ns/1ps
`include "esc_consts.vh"
module esc_config_regs (
    // clock and reset
    input  wire       mclk,
    input  wire       sys_rst,
    // configuration access, same clock domain
    input  wire       cfg_state,
    input  wire [7:0] configuration_index_register,
    input  wire       cfg_wr,
    input  wire       cfg_rd,
    input  wire [7:0] cfg_wdata,
    output reg  [7:0] cfg_rdata,
    output wire       cfg_hit,
    // ecp extended control mode field
    input  wire [2:0] ecr_mode,
    input  wire       par_mode_override,
    // parallel port controls
    output wire [1:0] par_mode,
    output wire       par_epp_active,
    output wire       par_ecp_active,
    output wire       par_spp_active,
    output wire       epp_rev_1_7,
    output wire       floppy_on_parallel_option_one,
    output wire       floppy_on_parallel_option_two,
    // serial prescaler ticks
    output wire       uart1_clk_tick,
    output wire       uart2_clk_tick,
    output wire       uart1_midi,
    output wire       uart2_midi,
    // floppy core signals in, same clock domain
    input  wire       fdc_dma_req_core,
    input  wire       fdc_irq_core,
    input  wire       fdc_byte_done,
    input  wire       fdc_fifo_en,
    input  wire       drive_density_one_fn,
    input  wire       density_override_bit,
    input  wire [7:0] fdc_out_core,
    // floppy pins
    output wire       floppy_dma_request,
    output wire       floppy_interrupt_request,
    output wire       drive_density_one_o,
    output wire       drive_density_one_oe,
    output wire [7:0] fdc_out_o,
    output wire [7:0] fdc_out_oe,
    output wire       fdc_push_pull,
    output wire [1:0] density_select,
    // parallel-routed floppy pins
    input  wire [7:0] pfdc_out_core,
    output wire [7:0] pfdc_out_o,
    output wire [7:0] pfdc_out_oe
);
    reg  [7:0] parallel_serial_extended_setup;
    reg  [7:0] floppy_output_configuration;
    reg        nb_strobe;
    wire       hit_ext;
    wire       hit_flp;
    wire       tri_on;
    wire       push_pull;
    wire       nonburst;

    // address decode only while in configuration state
    assign hit_ext = cfg_state & (configuration_index_register == `ESC_IDX_EXT_SETUP);
    assign hit_flp = cfg_state & (configuration_index_register == `ESC_IDX_FLOPPY_CFG);
    assign cfg_hit = hit_ext | hit_flp;

    // register writes; reserved bits masked so they never store
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            parallel_serial_extended_setup <= `ESC_RST_EXT_SETUP;
            floppy_output_configuration    <= `ESC_RST_FLOPPY_CFG;
        end else if (cfg_wr) begin
            if (hit_ext) begin
                parallel_serial_extended_setup <= cfg_wdata & `ESC_EXT_SETUP_MASK;
            end
            if (hit_flp) begin
                floppy_output_configuration <= cfg_wdata & `ESC_FLOPPY_CFG_MASK;
            end
        end
    end

    // read data registered; unmatched index reads zero
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_rdata <= 8'h00;
        end else if (cfg_rd & hit_ext) begin
            cfg_rdata <= parallel_serial_extended_setup & `ESC_EXT_SETUP_MASK;
        end else if (cfg_rd & hit_flp) begin
            cfg_rdata <= floppy_output_configuration & `ESC_FLOPPY_CFG_MASK;
        end else if (cfg_rd) begin
            cfg_rdata <= 8'h00;
        end
    end

    // parallel mode select, gated by the override from the other register bank
    assign par_mode = par_mode_override ? `ESC_PMODE_SPP :
                      parallel_serial_extended_setup[`ESC_PMODE_HI:`ESC_PMODE_LO];
    assign par_ecp_active = ((par_mode == `ESC_PMODE_ECP) | (par_mode == `ESC_PMODE_ECP_EPP)) &
                            (ecr_mode != `ESC_ECR_SPP) &
                            ~((par_mode == `ESC_PMODE_ECP_EPP) & (ecr_mode == `ESC_ECR_EPP));
    // ecr mode 100 yields epp only in the combined setting
    assign par_epp_active = (par_mode == `ESC_PMODE_EPP) |
                            ((par_mode == `ESC_PMODE_ECP_EPP) & (ecr_mode == `ESC_ECR_EPP));
    // ecr mode 000 falls back to standard in either ecp setting
    assign par_spp_active = (par_mode == `ESC_PMODE_SPP) |
                            (par_ecp_active == 1'b0 & par_epp_active == 1'b0);
    assign epp_rev_1_7 = parallel_serial_extended_setup[`ESC_EPP_TYPE_BIT];

    // floppy-on-parallel routing; code 11 selects nothing
    assign floppy_on_parallel_option_one =
        (parallel_serial_extended_setup[`ESC_PFLOP_HI:`ESC_PFLOP_LO] == 2'h1);
    assign floppy_on_parallel_option_two =
        (parallel_serial_extended_setup[`ESC_PFLOP_HI:`ESC_PFLOP_LO] == 2'h2);

    // serial prescalers; mclk stands in for the reference, so baud only matches at 24 MHz
    assign uart1_midi = parallel_serial_extended_setup[`ESC_MIDI1_BIT];
    assign uart2_midi = parallel_serial_extended_setup[`ESC_MIDI2_BIT];

    esc_prescaler #(
        .CNT_W (`ESC_DIV_CNT_W)
    ) u_pre1 (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .midi_en (uart1_midi),
        .tick    (uart1_clk_tick)
    );

    esc_prescaler #(
        .CNT_W (`ESC_DIV_CNT_W)
    ) u_pre2 (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .midi_en (uart2_midi),
        .tick    (uart2_clk_tick)
    );

    // floppy output type and tristate controls
    assign push_pull = floppy_output_configuration[`ESC_PUSH_PULL_BIT];
    assign tri_on    = floppy_output_configuration[`ESC_TRISTATE_BIT];
    assign nonburst  = floppy_output_configuration[`ESC_NONBURST_BIT];
    assign fdc_push_pull  = push_pull;
    assign density_select = floppy_output_configuration[`ESC_DENSITY_SELECT_HI:`ESC_DENSITY_SELECT_LO];

    // per-pin drive: open-drain drives only a low, push-pull drives both levels
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_fpin
            assign fdc_out_o[gi]  = push_pull ? fdc_out_core[gi] : 1'b0;
            assign fdc_out_oe[gi] = ~tri_on & (push_pull | ~fdc_out_core[gi]);
            // parallel-routed floppy ignores both type and tristate bits
            assign pfdc_out_o[gi]  = pfdc_out_core[gi];
            assign pfdc_out_oe[gi] = floppy_on_parallel_option_one |
                                     floppy_on_parallel_option_two;
        end
    endgenerate

    // density pin: forced high under override, high-z when tristated
    assign drive_density_one_o  = density_override_bit ? 1'b1 : drive_density_one_fn;
    assign drive_density_one_oe = ~tri_on;

    // non-burst strobe: one cycle per byte while the fifo runs
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            nb_strobe <= 1'b0;
        end else begin
            nb_strobe <= nonburst & fdc_fifo_en & fdc_byte_done;
        end
    end

    // burst passes the core request through; non-burst with the fifo enabled replaces it with the strobe
    assign floppy_dma_request = (nonburst & fdc_fifo_en) ? nb_strobe : fdc_dma_req_core;
    assign floppy_interrupt_request = (nonburst & fdc_fifo_en) ? (nb_strobe | fdc_irq_core)
                                                               : fdc_irq_core;
endmodule

// [hw/esc_consts.vh]
// constants for the extended setup configuration register pair
`ifndef ESC_CONSTS_VH
`define ESC_CONSTS_VH
`define ESC_IDX_EXT_SETUP     8'h04
`define ESC_IDX_FLOPPY_CFG    8'h05
`define ESC_RST_EXT_SETUP     8'h00
`define ESC_RST_FLOPPY_CFG    8'h00
`define ESC_EXT_SETUP_MASK    8'h7F
`define ESC_FLOPPY_CFG_MASK   8'h1F
`define ESC_PMODE_LO          0
`define ESC_PMODE_HI          1
`define ESC_PFLOP_LO          2
`define ESC_PFLOP_HI          3
`define ESC_MIDI1_BIT         4
`define ESC_MIDI2_BIT         5
`define ESC_EPP_TYPE_BIT      6
`define ESC_PUSH_PULL_BIT     0
`define ESC_TRISTATE_BIT      1
`define ESC_NONBURST_BIT      2
`define ESC_DENSITY_SELECT_LO         3
`define ESC_DENSITY_SELECT_HI         4
`define ESC_PMODE_SPP         2'h0
`define ESC_PMODE_EPP         2'h1
`define ESC_PMODE_ECP         2'h2
`define ESC_PMODE_ECP_EPP     2'h3
`define ESC_ECR_EPP           3'h4
`define ESC_ECR_SPP           3'h0
`define ESC_DIV_NORMAL        4'hD
`define ESC_DIV_MIDI          4'hC
`define ESC_DIV_CNT_W         4
`endif

// [hw/esc_prescaler.v]
// serial clock prescaler: one enable pulse every 12 or 13 reference cycles
`timescale 1ns/1ps
`include "esc_consts.vh"
module esc_prescaler #(
    parameter CNT_W = `ESC_DIV_CNT_W
) (
    // clock and reset
    input  wire             mclk,
    input  wire             sys_rst,
    // control
    input  wire             midi_en,
    // output
    output reg              tick
);
    reg  [CNT_W-1:0] count;
    wire [CNT_W-1:0] limit;

    // terminal count picks the divisor; a change applies to the period already counting
    assign limit = midi_en ? (`ESC_DIV_MIDI - 4'h1) : (`ESC_DIV_NORMAL - 4'h1);

    // free running divider
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            count <= {CNT_W{1'b0}};
            tick  <= 1'b0;
        end else if (count >= limit) begin
            count <= {CNT_W{1'b0}};
            tick  <= 1'b1;
        end else begin
            count <= count + 4'h1;
            tick  <= 1'b0;
        end
    end
endmodule

// [verif/esc_properties.sv]
// concurrent checks on the ports of the configuration register pair
`timescale 1ns/1ps
module esc_properties (
    // clock and reset
    input wire       mclk,
    input wire       sys_rst,
    // configuration access
    input wire       cfg_state, cfg_wr, cfg_rd, cfg_hit,
    input wire [7:0] configuration_index_register, cfg_wdata, cfg_rdata,
    // parallel and serial controls
    input wire [2:0] ecr_mode,
    input wire [1:0] par_mode,
    input wire       par_mode_override, par_epp_active, epp_rev_1_7,
    input wire       uart1_clk_tick, uart1_midi, uart2_midi,
    // floppy pins
    input wire       density_override_bit, drive_density_one_fn, drive_density_one_o,
    input wire       drive_density_one_oe, fdc_push_pull,
    input wire [7:0] fdc_out_core, fdc_out_o, fdc_out_oe, pfdc_out_core, pfdc_out_o
);
    wire idx_ok = (configuration_index_register == 8'h04) || (configuration_index_register == 8'h05);

    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // a full write of the setup register, and eleven quiet cycles of the midi divider
    sequence s_setup_all;
        cfg_wr && cfg_hit && !par_mode_override && configuration_index_register == 8'h04 && cfg_wdata == 8'hFF;
    endsequence
    sequence s_gap12;
        (!uart1_clk_tick)[*8] ##1 (!uart1_clk_tick)[*3];
    endsequence

    a_hit_decode: assert property (cfg_hit == (cfg_state && idx_ok))
        else $error("index decode wrong");
    a_refused_rd: assert property (cfg_rd && !cfg_hit |=> cfg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_reserved_zero: assert property (cfg_rd |=> cfg_rdata[7] == 1'b0)
        else $error("reserved bit read as one");
    a_setup_fields: assert property (s_setup_all |=> uart1_midi && uart2_midi && epp_rev_1_7 && par_mode == 2'h3)
        else $error("setup fields not applied");
    a_epp_select: assert property (!par_mode_override && par_mode == 2'h3 && ecr_mode == 3'h4 |-> par_epp_active)
        else $error("epp not entered");
    a_open_drain: assert property (!fdc_push_pull |-> fdc_out_o == 8'h00 && (fdc_out_oe & fdc_out_core) == 8'h00)
        else $error("open drain drives high");
    a_tri_all: assert property (!drive_density_one_oe |-> fdc_out_oe == 8'h00)
        else $error("pins driven while tristated");
    a_density_force: assert property (drive_density_one_oe |-> drive_density_one_o == (density_override_bit | drive_density_one_fn))
        else $error("density pin value wrong");
    a_par_bypass: assert property (pfdc_out_o == pfdc_out_core)
        else $error("parallel floppy path altered");
    // a late tick is fine only when midi was switched off meanwhile
    a_midi_gap: assert property (uart1_clk_tick && uart1_midi |=> s_gap12 ##1 (uart1_clk_tick || !uart1_midi))
        else $error("midi tick spacing wrong");
endmodule

// [verif/esc_config_regs_test.sv]
// self-checking bench for the configuration register pair
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module esc_config_regs_test;
    reg        mclk = 0, sys_rst = 1, cfg_state = 1, cfg_wr = 0, cfg_rd = 0, par_mode_override = 0;
    reg  [7:0] configuration_index_register = 8'h00, cfg_wdata = 8'h00, fdc_out_core = 8'hA5, pfdc_out_core = 8'h3C;
    reg  [2:0] ecr_mode = 3'h1;
    reg        fdc_dma_req_core = 0, fdc_irq_core = 0, fdc_byte_done = 0, fdc_fifo_en = 0;
    reg        drive_density_one_fn = 0, density_override_bit = 0;
    wire [7:0] cfg_rdata, fdc_out_o, fdc_out_oe, pfdc_out_o, pfdc_out_oe;
    wire [1:0] par_mode, density_select;
    wire       cfg_hit, par_epp_active, par_ecp_active, par_spp_active, epp_rev_1_7, fdc_push_pull;
    wire       floppy_on_parallel_option_one, floppy_on_parallel_option_two, uart1_clk_tick, uart2_clk_tick;
    wire       uart1_midi, uart2_midi, floppy_dma_request, floppy_interrupt_request;
    wire       drive_density_one_o, drive_density_one_oe;
    int        err_count = 0, check_count = 0, cyc = 0, n = 0;
    reg  [7:0] d;

    esc_config_regs u_dut (.mclk, .sys_rst, .cfg_state, .configuration_index_register, .cfg_wr, .cfg_rd,
        .cfg_wdata, .cfg_rdata, .cfg_hit, .ecr_mode, .par_mode_override, .par_mode, .par_epp_active,
        .par_ecp_active, .par_spp_active, .epp_rev_1_7, .floppy_on_parallel_option_one,
        .floppy_on_parallel_option_two, .uart1_clk_tick, .uart2_clk_tick, .uart1_midi, .uart2_midi,
        .fdc_dma_req_core, .fdc_irq_core, .fdc_byte_done, .fdc_fifo_en, .drive_density_one_fn,
        .density_override_bit, .fdc_out_core, .floppy_dma_request, .floppy_interrupt_request,
        .drive_density_one_o, .drive_density_one_oe, .fdc_out_o, .fdc_out_oe, .fdc_push_pull,
        .density_select, .pfdc_out_core, .pfdc_out_o, .pfdc_out_oe);

    // clock, and a watchdog well past the couple hundred cycles the tests need
    initial forever #10 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc > 5000) begin
            err_count++;
            give_verdict();
        end
    end

    // one write cycle; returns just after the taking edge so effects have landed
    task wr(input [7:0] i, input [7:0] v);
        @(posedge mclk);
        configuration_index_register <= i;
        cfg_wdata <= v;
        cfg_wr <= 1;
        @(posedge mclk);
        cfg_wr <= 0;
        #1;
    endtask
    // read data is registered on the edge that takes the strobe
    task rd(input [7:0] i, output [7:0] v);
        @(posedge mclk);
        configuration_index_register <= i;
        cfg_rd <= 1;
        @(posedge mclk);
        cfg_rd <= 0;
        #1 v = cfg_rdata;
    endtask
    // edges from one tick to the next of the chosen prescaler
    task gap(input bit sel, output int k);
        k = 0;
        do @(posedge mclk) #1; while ((sel ? uart2_clk_tick : uart1_clk_tick) !== 1'b1);
        do begin @(posedge mclk) #1; k++; end while ((sel ? uart2_clk_tick : uart1_clk_tick) !== 1'b1);
    endtask
    task give_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        sys_rst <= 0;
        rd(8'h04, d); `CHK(d, 8'h00)
        rd(8'h05, d); `CHK(d, 8'h00)
        $display("reset values done");
        wr(8'h04, 8'hFF); rd(8'h04, d); `CHK(d, 8'h7F)
        `CHK({uart1_midi, uart2_midi, epp_rev_1_7}, 3'h7)
        wr(8'h05, 8'hFF); rd(8'h05, d); `CHK(d, 8'h1F)
        `CHK(density_select, 2'h3)
        @(posedge mclk) cfg_state <= 0;
        wr(8'h04, 8'h00); `CHK(cfg_hit, 1'b0)
        cfg_state <= 1;
        rd(8'h04, d); `CHK(d, 8'h7F)
        rd(8'h06, d); `CHK(d, 8'h00)
        $display("access done");
        for (int m = 0; m < 4; m++) begin
            wr(8'h04, 8'(m * 5));
            `CHK(par_mode, 2'(m))
            `CHK({floppy_on_parallel_option_one, floppy_on_parallel_option_two}, {m == 1, m == 2})
            `CHK(par_ecp_active, m >= 2)
            `CHK(pfdc_out_oe, (m == 1 || m == 2) ? 8'hFF : 8'h00)
        end
        ecr_mode <= 3'h4; #1 `CHK(par_epp_active, 1'b1)
        ecr_mode <= 3'h0; #1 `CHK(par_spp_active, 1'b1)
        $display("modes done");
        wr(8'h05, 8'h00); `CHK(fdc_out_oe, 8'h5A)
        wr(8'h05, 8'h01); `CHK({fdc_out_o, fdc_out_oe}, 16'hA5FF)
        `CHK({drive_density_one_o, drive_density_one_oe}, 2'h1)
        density_override_bit <= 1;
        #1 `CHK({drive_density_one_o, drive_density_one_oe}, 2'h3)
        wr(8'h05, 8'h03); `CHK({fdc_out_oe, drive_density_one_oe}, 9'h000)
        `CHK(pfdc_out_o, 8'h3C)
        $display("floppy pins done");
        wr(8'h05, 8'h04);
        fdc_fifo_en <= 1;
        @(posedge mclk) fdc_byte_done <= 1;
        @(posedge mclk) fdc_byte_done <= 0;
        #1 `CHK({floppy_dma_request, floppy_interrupt_request}, 2'h3)
        @(posedge mclk) #1 `CHK(floppy_dma_request, 1'b0)
        $display("non-burst done");
        wr(8'h04, 8'h10);
        gap(0, n); gap(0, n); `CHK(n, 12)
        gap(1, n); gap(1, n); `CHK(n, 13)
        $display("prescaler done");
        give_verdict();
    end
endmodule

bind esc_config_regs esc_properties u_chk (.mclk, .sys_rst, .cfg_state, .cfg_wr, .cfg_rd, .cfg_hit,
    .configuration_index_register, .cfg_wdata, .cfg_rdata, .ecr_mode, .par_mode, .par_mode_override,
    .par_epp_active, .epp_rev_1_7, .uart1_clk_tick, .uart1_midi, .uart2_midi, .density_override_bit,
    .drive_density_one_fn, .drive_density_one_o, .drive_density_one_oe, .fdc_push_pull, .fdc_out_core,
    .fdc_out_o, .fdc_out_oe, .pfdc_out_core, .pfdc_out_o);
